// file: inc/sram_port_pkg.sv
// Shared widths, counts and reset values for the DDR burst-of-two SRAM port logic
package sram_port_pkg;
    // ==========================================================
    // Data path geometry
    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int LANES = DATA_W / LANE_W;
    localparam int ADDR_W = 18;
    localparam int MEM_DEPTH = 1 << ADDR_W;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = 2 * DATA_W;
    // Ready drops once this many slots or fewer remain
    localparam int FIFO_SLACK = 2;

    // ==========================================================
    // Synchroniser vector layout
    localparam int SYNC_W = 2 + 2 + 2 * ADDR_W + DATA_W + LANES + 2;
    localparam int SY_PDWEAK = 0;
    localparam int SY_PUWEAK = 1;
    localparam int SY_MASK = 2;
    localparam int SY_WDATA = SY_MASK + LANES;
    localparam int SY_WADDR = SY_WDATA + DATA_W;
    localparam int SY_RADDR = SY_WADDR + ADDR_W;
    localparam int SY_WSEL = SY_RADDR + ADDR_W;
    localparam int SY_RSEL = SY_WSEL + 1;
    localparam int SY_OCLKN = SY_RSEL + 1;
    localparam int SY_OCLK = SY_OCLKN + 1;

    // ==========================================================
    // Impedance calibration
    localparam int CLK_MHZ = 125;
    localparam int IMP_CODE_W = 6;
    localparam logic [IMP_CODE_W-1:0] IMP_CODE_RESET = 6'h20;
    localparam logic [IMP_CODE_W-1:0] IMP_CODE_MAX = 6'h3f;
    localparam logic [IMP_CODE_W-1:0] IMP_CODE_MIN = 6'h00;
    localparam logic [IMP_CODE_W-1:0] IMP_STEP = 6'h01;
    localparam int EVAL_PERIOD_NS = 8192;
    localparam int EVAL_CYCLES = EVAL_PERIOD_NS * CLK_MHZ / 1000;
    localparam int EVAL_CNT_W = $clog2(EVAL_CYCLES);
    localparam int STARTUP_CYCLES = 32768;
    localparam int STARTUP_CNT_W = 16;
endpackage

// file: rtl/ddr_quad_sram_port.sv
// Port logic of a separate-I/O DDR burst-of-two SRAM with impedance calibration
`timescale 1ns/10ps
module ddr_quad_sram_port #(
    parameter int STARTUP_COUNT = sram_port_pkg::STARTUP_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic readSel_n,
    input wire logic [sram_port_pkg::ADDR_W-1:0] readAddr,
    input wire logic writeSel_n,
    input wire logic [sram_port_pkg::ADDR_W-1:0] writeAddr,
    input wire logic [sram_port_pkg::DATA_W-1:0] writeData,
    input wire logic [sram_port_pkg::LANES-1:0] byteMask_n,
    input wire logic outClk,
    input wire logic outClk_n,
    input wire logic pullUpWeak,
    input wire logic pullDownWeak,
    output logic [sram_port_pkg::DATA_W-1:0] readData,
    output logic readDataOe,
    output logic echoClockOut,
    output logic echoClockOut_n,
    output logic readReady,
    output logic [sram_port_pkg::IMP_CODE_W-1:0] pullUpCode,
    output logic [sram_port_pkg::IMP_CODE_W-1:0] pullDownCode,
    output logic driveSettled
);
    localparam int DW = sram_port_pkg::DATA_W;
    localparam int LW = sram_port_pkg::LANE_W;
    localparam int NL = sram_port_pkg::LANES;
    localparam int AW = sram_port_pkg::ADDR_W;
    localparam int CW = sram_port_pkg::IMP_CODE_W;
    localparam int FW = sram_port_pkg::FIFO_W;
    localparam int LVW = $clog2(sram_port_pkg::FIFO_DEPTH) + 1;
    localparam logic [LVW-1:0] READY_LEVEL =
        LVW'(sram_port_pkg::FIFO_DEPTH - sram_port_pkg::FIFO_SLACK);
    localparam logic [sram_port_pkg::EVAL_CNT_W-1:0] EVAL_LAST =
        sram_port_pkg::EVAL_CNT_W'(sram_port_pkg::EVAL_CYCLES - 1);
    localparam logic [sram_port_pkg::STARTUP_CNT_W:0] STARTUP_LAST =
        (sram_port_pkg::STARTUP_CNT_W+1)'(STARTUP_COUNT - 1);

    // ==========================================================
    // Pin synchronisers
    logic [sram_port_pkg::SYNC_W-1:0] pinMeta_q;
    logic [sram_port_pkg::SYNC_W-1:0] pinSync_q;
    wire [sram_port_pkg::SYNC_W-1:0] pinRaw = {outClk, outClk_n, readSel_n, writeSel_n,
        readAddr, writeAddr, writeData, byteMask_n, pullUpWeak, pullDownWeak};

    always_ff @(posedge clk) begin
        pinMeta_q <= pinRaw;
        pinSync_q <= pinMeta_q;
    end

    wire sOutClk = pinSync_q[sram_port_pkg::SY_OCLK];
    wire sOutClkN = pinSync_q[sram_port_pkg::SY_OCLKN];
    wire sReadSelN = pinSync_q[sram_port_pkg::SY_RSEL];
    wire sWriteSelN = pinSync_q[sram_port_pkg::SY_WSEL];
    wire [AW-1:0] sReadAddr = pinSync_q[sram_port_pkg::SY_RADDR +: AW];
    wire [AW-1:0] sWriteAddr = pinSync_q[sram_port_pkg::SY_WADDR +: AW];
    wire [DW-1:0] sWriteData = pinSync_q[sram_port_pkg::SY_WDATA +: DW];
    wire [NL-1:0] sMaskN = pinSync_q[sram_port_pkg::SY_MASK +: NL];
    wire sPuWeak = pinSync_q[sram_port_pkg::SY_PUWEAK];
    wire sPdWeak = pinSync_q[sram_port_pkg::SY_PDWEAK];

    // ==========================================================
    // Input clock phases: true edge on even cycles, complementary on odd
    logic kPhase_q;
    wire trueEdge = !kPhase_q;
    wire compEdge = kPhase_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            kPhase_q <= 1'b0;
        end else begin
            kPhase_q <= !kPhase_q;
        end
    end

    // ==========================================================
    // Command capture; both ports sampled independently
    logic readPend_q;
    logic [AW-1:0] readAddr_q;
    logic writePend_q;
    logic [DW-1:0] writeBeat1_q;
    logic [NL-1:0] mask1N_q;
    logic readReady_q;

    wire readTake = trueEdge && !sReadSelN && readReady_q;
    wire writeTake = trueEdge && !sWriteSelN;

    always_ff @(posedge clk) begin
        if (srst) begin
            readPend_q <= 1'b0;
            writePend_q <= 1'b0;
            readAddr_q <= '0;
            writeBeat1_q <= '0;
            mask1N_q <= '1;
        end else if (trueEdge) begin
            // Ports do not gate each other
            readPend_q <= readTake;
            writePend_q <= writeTake;
            readAddr_q <= sReadAddr;
            writeBeat1_q <= sWriteData;
            mask1N_q <= sMaskN;
        end
    end

    // ==========================================================
    // Array and complementary-edge write with per-lane masking
    logic [DW-1:0] memBeat1 [sram_port_pkg::MEM_DEPTH];
    logic [DW-1:0] memBeat2 [sram_port_pkg::MEM_DEPTH];

    // Address and beat two arrive on the complementary edge
    wire [AW-1:0] wrAddr = sWriteAddr;
    wire [DW-1:0] writeBeat2 = sWriteData;
    wire [NL-1:0] mask2N = sMaskN;
    wire writeAny = writePend_q && compEdge && !(&mask1N_q && &mask2N);
    wire [NL-1:0] lane1En = ~mask1N_q;
    wire [NL-1:0] lane2En = ~mask2N;

    // Lane i is bits i*9..i*9+8; only lanes 0-3 whose mask bit is low are written
    always_ff @(posedge clk) begin
        if (writeAny) begin
            for (int i = 0; i < NL; i++) begin
                if (lane1En[i]) begin
                    memBeat1[wrAddr][i*LW +: LW] <= writeBeat1_q[i*LW +: LW];
                end
                if (lane2En[i]) begin
                    memBeat2[wrAddr][i*LW +: LW] <= writeBeat2[i*LW +: LW];
                end
            end
        end
    end

    // ==========================================================
    // Read lookup with pass-through of the write in the same cycle
    // Array is read before this cycle's write lands, so merge here
    wire [DW-1:0] stored1 = memBeat1[readAddr_q];
    wire [DW-1:0] stored2 = memBeat2[readAddr_q];
    wire passThru = writePend_q && (readAddr_q == wrAddr);
    wire [DW-1:0] merged1;
    wire [DW-1:0] merged2;

    generate
        for (genvar g = 0; g < NL; g++) begin : g_lane
            assign merged1[g*LW +: LW] = (passThru && lane1En[g]) ?
                writeBeat1_q[g*LW +: LW] : stored1[g*LW +: LW];
            assign merged2[g*LW +: LW] = (passThru && lane2En[g]) ?
                writeBeat2[g*LW +: LW] : stored2[g*LW +: LW];
        end
    endgenerate

    // ==========================================================
    // Read return queue between lookup and output launch
    wire fifoPush = readPend_q && compEdge;
    wire fifoInReady;
    wire fifoOutValid;
    wire [FW-1:0] fifoOutData;
    wire [LVW-1:0] fifoLevel;
    logic launchEdge;

    sync_fifo #(
        .WIDTH(FW),
        .DEPTH(sram_port_pkg::FIFO_DEPTH)
    ) u_return_fifo (
        .clk(clk),
        .srst(srst),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .inData({merged2, merged1}),
        .outValid(fifoOutValid),
        .outReady(launchEdge),
        .outData(fifoOutData),
        .level(fifoLevel)
    );

    // Registered ready leaves two slots of slack for the pushes in flight
    always_ff @(posedge clk) begin
        if (srst) begin
            readReady_q <= 1'b0;
        end else begin
            readReady_q <= fifoInReady && (fifoLevel < READY_LEVEL);
        end
    end

    // ==========================================================
    // Output launch and echo clocks
    logic outClkDly_q;
    always_ff @(posedge clk) begin
        outClkDly_q <= sOutClk;
    end

    wire outClksTied = sOutClk && sOutClkN;
    wire outClkRise = sOutClk && !outClkDly_q && !sOutClkN;
    wire launchPhase = outClksTied ? trueEdge : sOutClk;
    assign launchEdge = outClksTied ? trueEdge : outClkRise;

    logic [DW-1:0] readData_q;
    logic readOe_q;
    logic beat2Pend_q;
    logic [DW-1:0] beat2Hold_q;
    logic echo_q;
    logic echoN_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            readData_q <= '0;
            readOe_q <= 1'b0;
            beat2Pend_q <= 1'b0;
            beat2Hold_q <= '0;
        end else if (launchEdge) begin
            // No read queued: outputs float for both beats
            readOe_q <= fifoOutValid;
            readData_q <= fifoOutData[DW-1:0];
            beat2Hold_q <= fifoOutData[FW-1:DW];
            beat2Pend_q <= fifoOutValid;
        end else if (beat2Pend_q) begin
            readData_q <= beat2Hold_q;
            beat2Pend_q <= 1'b0;
        end
    end

    // Free running regardless of port selection
    always_ff @(posedge clk) begin
        if (srst) begin
            echo_q <= 1'b0;
            echoN_q <= 1'b1;
        end else begin
            echo_q <= launchPhase;
            echoN_q <= !launchPhase;
        end
    end

    // ==========================================================
    // Impedance calibration
    logic [sram_port_pkg::EVAL_CNT_W-1:0] evalCnt_q;
    logic [sram_port_pkg::STARTUP_CNT_W:0] startCnt_q;
    logic settled_q;
    logic puPend_q;
    logic pdPend_q;
    logic [CW-1:0] puCode_q;
    logic [CW-1:0] pdCode_q;

    wire evalTick = (evalCnt_q == EVAL_LAST);
    // A driver only retunes while its own half is idle
    wire pdAllowed = !readOe_q || (&readData_q);
    wire puAllowed = !readOe_q || !(|readData_q);
    wire pdApply = (pdPend_q || evalTick) && pdAllowed;
    wire puApply = (puPend_q || evalTick) && puAllowed;

    always_ff @(posedge clk) begin
        if (srst) begin
            evalCnt_q <= '0;
        end else if (evalTick) begin
            evalCnt_q <= '0;
        end else begin
            evalCnt_q <= evalCnt_q + 1'b1;
        end
    end

    // Counts selected or deselected; settles once the count is done
    always_ff @(posedge clk) begin
        if (srst) begin
            startCnt_q <= '0;
            settled_q <= 1'b0;
        end else if (!settled_q) begin
            startCnt_q <= startCnt_q + 1'b1;
            settled_q <= (startCnt_q == STARTUP_LAST);
        end
    end

    // Request waits until the driver is free to retune
    always_ff @(posedge clk) begin
        if (srst) begin
            puPend_q <= 1'b0;
            pdPend_q <= 1'b0;
        end else begin
            puPend_q <= (puPend_q || evalTick) && !puAllowed;
            pdPend_q <= (pdPend_q || evalTick) && !pdAllowed;
        end
    end

    // Binary-weighted legs; single step, saturating at the ends
    always_ff @(posedge clk) begin
        if (srst) begin
            puCode_q <= sram_port_pkg::IMP_CODE_RESET;
            pdCode_q <= sram_port_pkg::IMP_CODE_RESET;
        end else begin
            if (puApply) begin
                if (sPuWeak && puCode_q != sram_port_pkg::IMP_CODE_MAX) begin
                    puCode_q <= puCode_q + sram_port_pkg::IMP_STEP;
                end else if (!sPuWeak && puCode_q != sram_port_pkg::IMP_CODE_MIN) begin
                    puCode_q <= puCode_q - sram_port_pkg::IMP_STEP;
                end
            end
            if (pdApply) begin
                if (sPdWeak && pdCode_q != sram_port_pkg::IMP_CODE_MAX) begin
                    pdCode_q <= pdCode_q + sram_port_pkg::IMP_STEP;
                end else if (!sPdWeak && pdCode_q != sram_port_pkg::IMP_CODE_MIN) begin
                    pdCode_q <= pdCode_q - sram_port_pkg::IMP_STEP;
                end
            end
        end
    end

    // ==========================================================
    // Outputs
    assign readData = readData_q;
    assign readDataOe = readOe_q;
    assign echoClockOut = echo_q;
    assign echoClockOut_n = echoN_q;
    assign readReady = readReady_q;
    assign pullUpCode = puCode_q;
    assign pullDownCode = pdCode_q;
    assign driveSettled = settled_q;
endmodule

// file: rtl/sync_fifo.sv
// Synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/10ps
module sync_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH):0] level
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [PTR_W:0] count_q;
    wire pushOk = inValid && inReady;
    wire popOk = outValid && outReady;

    assign inReady = (count_q != (PTR_W+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = store[rdPtr_q];
    assign level = count_q;

    always_ff @(posedge clk) begin
        if (pushOk) begin
            store[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (pushOk) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (popOk) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            count_q <= count_q + (PTR_W+1)'(pushOk) - (PTR_W+1)'(popOk);
        end
    end
endmodule

// file: verif/sram_ctrl_model.sv
// Controller-side model issuing burst reads and writes to the port
`timescale 1ns/10ps
module sram_ctrl_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic [sram_port_pkg::DATA_W-1:0] readData,
    input wire logic readDataOe,
    input wire logic readReady,
    output logic readSel_n,
    output logic [sram_port_pkg::ADDR_W-1:0] readAddr,
    output logic writeSel_n,
    output logic [sram_port_pkg::ADDR_W-1:0] writeAddr,
    output logic [sram_port_pkg::DATA_W-1:0] writeData,
    output logic [sram_port_pkg::LANES-1:0] byteMask_n
);
    // High while the current cycle is a complementary one
    logic compPhase_q;
    always_ff @(posedge clk) begin
        compPhase_q <= srst ? 1'b0 : ~compPhase_q;
    end

    initial begin
        readSel_n = 1'b1;
        writeSel_n = 1'b1;
        readAddr = '0;
        writeAddr = '0;
        writeData = '0;
        byteMask_n = '1;
    end

    // Word is {beat two, beat one}; mask bits [3:0] go with beat one
    task automatic issue(input logic rd, input logic [17:0] ra, input logic wr,
        input logic [17:0] wa, input logic [71:0] w, input logic [7:0] m,
        output logic [71:0] rw);
        int n;
        rw = 'x;
        n = 0;
        @(posedge clk);
        while ((compPhase_q !== 1'b1 || readReady !== 1'b1) && n < 50) begin
            @(posedge clk);
            n++;
        end
        readSel_n <= ~rd;
        readAddr <= ra;
        writeSel_n <= ~wr;
        writeData <= w[35:0];
        byteMask_n <= m[3:0];
        writeAddr <= wa;
        @(posedge clk);
        readSel_n <= 1'b1;
        writeSel_n <= 1'b1;
        writeData <= w[71:36];
        byteMask_n <= m[7:4];
        @(posedge clk);
        // Released data and address lines show the inverse, never a stale copy; masks go all ones
        writeData <= ~w[71:36];
        readAddr <= ~ra;
        writeAddr <= ~wa;
        byteMask_n <= '1;
        n = 0;
        while (rd && readDataOe !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (rd && readDataOe === 1'b1) begin
            rw[35:0] = readData;
            @(posedge clk);
            rw[71:36] = readData;
        end
    endtask
endmodule

// file: verif/sram_port_properties.sv
// Concurrent checks on the pins of the SRAM port logic
`timescale 1ns/10ps
module sram_port_properties #(
    parameter int STARTUP_COUNT = 64
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic readSel_n,
    input wire logic outClk,
    input wire logic outClk_n,
    input wire logic [sram_port_pkg::DATA_W-1:0] readData,
    input wire logic readDataOe,
    input wire logic echoClockOut,
    input wire logic echoClockOut_n,
    input wire logic [sram_port_pkg::IMP_CODE_W-1:0] pullUpCode,
    input wire logic [sram_port_pkg::IMP_CODE_W-1:0] pullDownCode,
    input wire logic driveSettled
);
    // ==========================================================
    // Cycles since reset release, saturating past the start-up span
    int unsigned upTime_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            upTime_q <= 0;
        end else if (upTime_q < STARTUP_COUNT + 8) begin
            upTime_q <= upTime_q + 1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // ==========================================================
    // Assertions
    upStep_a: assert property ($changed(pullUpCode) |->
        (pullUpCode - $past(pullUpCode)) inside {6'h01, 6'h3f})
        else $error("pull-up code moved more than one step");
    downStep_a: assert property ($changed(pullDownCode) |->
        (pullDownCode - $past(pullDownCode)) inside {6'h01, 6'h3f})
        else $error("pull-down code moved more than one step");
    // Evaluations are far apart, so a code never moves twice in a row
    evalGap_a: assert property ($changed(pullUpCode) |=> $stable(pullUpCode) [*8])
        else $error("pull-up code changed twice within eight cycles");
    downWhen_a: assert property ($changed(pullDownCode) |->
        $past(!readDataOe || (&readData)))
        else $error("pull-down code changed while driving a zero");
    upWhen_a: assert property ($changed(pullUpCode) |->
        $past(!readDataOe || !(|readData)))
        else $error("pull-up code changed while driving a one");
    echoRuns_a: assert property (outClk && outClk_n && $past(outClk && outClk_n, 4)
        && !$past(srst) && !$past(srst, 2) |-> echoClockOut != $past(echoClockOut))
        else $error("echo clock stopped toggling");
    echoPair_a: assert property (echoClockOut_n == !echoClockOut)
        else $error("echo clock pair not complementary");
    readLatency_a: assert property ($rose(readDataOe) |->
        $past(!readSel_n, 5) || $past(!readSel_n, 6))
        else $error("read data driven without a read request");
    beatTwo_a: assert property ($rose(readDataOe) |=> readDataOe)
        else $error("second read beat not driven");
    settleEarly_a: assert property (driveSettled |-> upTime_q >= STARTUP_COUNT - 1)
        else $error("drive settled before start-up count");
    settleLate_a: assert property (upTime_q == STARTUP_COUNT + 4 |-> driveSettled)
        else $error("drive not settled after start-up count");

    cover property ($rose(readDataOe));
    cover property ($changed(pullUpCode));
    cover property ($rose(driveSettled));
endmodule

bind ddr_quad_sram_port sram_port_properties #(.STARTUP_COUNT(STARTUP_COUNT)) chk (
    .clk(clk),
    .srst(srst),
    .readSel_n(readSel_n),
    .outClk(outClk),
    .outClk_n(outClk_n),
    .readData(readData),
    .readDataOe(readDataOe),
    .echoClockOut(echoClockOut),
    .echoClockOut_n(echoClockOut_n),
    .pullUpCode(pullUpCode),
    .pullDownCode(pullDownCode),
    .driveSettled(driveSettled)
);

// file: verif/tb.sv
// Self-checking bench for the DDR burst-of-two SRAM port logic
`timescale 1ns/10ps
module tb;
    localparam int STARTUP = 64;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic pullUpWeak = 1'b0;
    logic pullDownWeak = 1'b0;
    logic freeOut = 1'b0;
    logic outClk = 1'b1;
    logic outClk_n = 1'b1;
    logic readSel_n;
    logic writeSel_n;
    logic [sram_port_pkg::ADDR_W-1:0] readAddr;
    logic [sram_port_pkg::ADDR_W-1:0] writeAddr;
    logic [sram_port_pkg::DATA_W-1:0] writeData;
    logic [sram_port_pkg::DATA_W-1:0] readData;
    logic [sram_port_pkg::LANES-1:0] byteMask_n;
    logic readDataOe;
    logic echoClockOut;
    logic echoClockOut_n;
    logic readReady;
    logic driveSettled;
    logic [sram_port_pkg::IMP_CODE_W-1:0] pullUpCode;
    logic [sram_port_pkg::IMP_CODE_W-1:0] pullDownCode;
    logic [71:0] mem [int];
    int fail_count = 0;
    int n_tests = 0;

    always #4 clk = ~clk;

    // Output clocks run free in t_outclk, tied high otherwise
    always @(posedge clk) begin
        outClk <= freeOut ? ~outClk : 1'b1;
        outClk_n <= freeOut ? outClk : 1'b1;
    end

    ddr_quad_sram_port #(.STARTUP_COUNT(STARTUP)) dut (
        .clk(clk), .srst(srst), .readSel_n(readSel_n), .readAddr(readAddr),
        .writeSel_n(writeSel_n), .writeAddr(writeAddr), .writeData(writeData),
        .byteMask_n(byteMask_n), .outClk(outClk), .outClk_n(outClk_n),
        .pullUpWeak(pullUpWeak), .pullDownWeak(pullDownWeak), .readData(readData),
        .readDataOe(readDataOe), .echoClockOut(echoClockOut),
        .echoClockOut_n(echoClockOut_n), .readReady(readReady),
        .pullUpCode(pullUpCode), .pullDownCode(pullDownCode), .driveSettled(driveSettled)
    );

    sram_ctrl_model ctrl (
        .clk(clk), .srst(srst), .readData(readData), .readDataOe(readDataOe),
        .readReady(readReady), .readSel_n(readSel_n), .readAddr(readAddr),
        .writeSel_n(writeSel_n), .writeAddr(writeAddr), .writeData(writeData),
        .byteMask_n(byteMask_n)
    );

    // ==========================================================
    // Shared helpers
    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [71:0] merge(input logic [71:0] old, input logic [71:0] w,
        input logic [7:0] m);
        logic [71:0] r;
        r = old;
        for (int i = 0; i < 8; i++) begin
            if (!m[i]) begin
                r[9*i+:9] = w[9*i+:9];
            end
        end
        return r;
    endfunction

    task automatic xfer(input logic rd, input logic [17:0] ra, input logic wr,
        input logic [17:0] wa, input logic [71:0] w, input logic [7:0] m);
        logic [71:0] got;
        logic [71:0] exp;
        exp = 'x;
        if (rd) begin
            exp = (wr && ra == wa) ? merge(mem[ra], w, m) : mem[ra];
        end
        ctrl.issue(rd, ra, wr, wa, w, m, got);
        if (rd) check(got, exp);
        if (wr) mem[wa] = merge(mem.exists(wa) ? mem[wa] : 72'hx, w, m);
    endtask

    task wrap_up;
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task t_reset;
        check(pullUpCode, sram_port_pkg::IMP_CODE_RESET);
        check(pullDownCode, sram_port_pkg::IMP_CODE_RESET);
        check(readDataOe, 1'b0);
        check(driveSettled, 1'b0);
        check(readReady, 1'b1);
        $display("t_reset done");
    endtask

    task t_idle;
        logic prev;
        int tog;
        int busy;
        tog = 0;
        busy = 0;
        prev = echoClockOut;
        repeat (20) begin
            @(posedge clk);
            tog += (echoClockOut !== prev);
            busy += (readDataOe !== 1'b0);
            prev = echoClockOut;
        end
        check(tog, 20);
        check(busy, 0);
        $display("t_idle done");
    endtask

    task t_basic;
        xfer(1'b0, 18'h0, 1'b1, 18'h00011, 72'h123456789abcdef012, 8'h00);
        xfer(1'b1, 18'h00011, 1'b0, 18'h0, 72'h0, 8'hff);
        xfer(1'b1, 18'h00011, 1'b0, 18'h0, 72'h0, 8'hff);
        $display("t_basic done");
    endtask

    task t_masks;
        xfer(1'b0, 18'h0, 1'b1, 18'h00022, 72'h0f0e0d0c0b0a090807, 8'h00);
        for (int m = 0; m < 16; m++) begin
            xfer(1'b0, 18'h0, 1'b1, 18'h00022, ~mem[18'h00022], {~4'(m), 4'(m)});
            xfer(1'b1, 18'h00022, 1'b0, 18'h0, 72'h0, 8'hff);
        end
        xfer(1'b0, 18'h0, 1'b1, 18'h00022, 72'h0, 8'hff);
        xfer(1'b1, 18'h00022, 1'b0, 18'h0, 72'h0, 8'hff);
        $display("t_masks done");
    endtask

    task t_pass;
        xfer(1'b1, 18'h00011, 1'b1, 18'h00011, ~mem[18'h00011], 8'h5a);
        xfer(1'b1, 18'h00011, 1'b1, 18'h00022, 72'h55aa55aa55aa55aa55, 8'h00);
        xfer(1'b1, 18'h00022, 1'b0, 18'h0, 72'h0, 8'hff);
        $display("t_pass done");
    endtask

    task t_outclk;
        freeOut <= 1'b1;
        repeat (6) @(posedge clk);
        xfer(1'b1, 18'h00022, 1'b0, 18'h0, 72'h0, 8'hff);
        xfer(1'b1, 18'h00011, 1'b1, 18'h00011, 72'h0, 8'h0f);
        freeOut <= 1'b0;
        repeat (6) @(posedge clk);
        $display("t_outclk done");
    endtask

    task t_settle;
        repeat (STARTUP + 10) @(posedge clk);
        check(driveSettled, 1'b1);
        $display("t_settle done");
    endtask

    task t_imp;
        logic [5:0] old;
        logic [5:0] pdOld;
        int n;
        pullUpWeak <= 1'b1;
        pullDownWeak <= 1'b1;
        repeat (4) @(posedge clk);
        old = pullUpCode;
        pdOld = pullDownCode;
        n = 0;
        while (pullUpCode === old && n < 1100) begin
            @(posedge clk);
            n++;
        end
        check(pullUpCode, old + 6'h01);
        check(pullDownCode, pdOld + 6'h01);
        repeat (1000) @(posedge clk);
        check(pullUpCode, old + 6'h01);
        repeat (40) @(posedge clk);
        check(pullUpCode, old + 6'h02);
        check(pullDownCode, pdOld + 6'h02);
        $display("t_imp done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset();
        t_idle();
        t_basic();
        t_masks();
        t_pass();
        t_outclk();
        t_settle();
        t_imp();
        wrap_up();
    end

    // Tests need about 2000 cycles; allow ten times that
    initial begin
        #(8 * 20000);
        fail_count++;
        wrap_up();
    end
endmodule
